// file: hlfc_pkg.sv
// Constants and types of the link FIFO control block
package hlfc_pkg;

  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] FILL_CTRL_OFS = 8'hB2;
  localparam logic [7:0] FIFO_PORT_OFS = 8'hB3;
  localparam logic [7:0] STATUS_OFS = 8'hB4;
  localparam logic [7:0] EMPTY_CTRL_OFS = 8'hB6;

  // --------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------
  localparam int FILL_LIMIT_LSB = 6;
  localparam int THRESH_MSB = 5;
  localparam int ST_IN_PROG = 4;
  localparam int ST_NEXT_STAT = 3;
  localparam int ST_EMPTY = 2;
  localparam int ST_NEAR = 1;
  localparam int ST_FULL = 0;
  localparam logic [7:0] FILL_CTRL_RST = 8'h00;
  localparam logic [7:0] EMPTY_CTRL_RST = 8'h00;

  // --------------------------------------------------------------------
  // FIFO geometry and framing constants
  // --------------------------------------------------------------------
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  localparam logic [5:0] E1_FILL_STEP = 6'h08;
  localparam logic [5:0] T1_FILL_STEP = 6'h06;
  localparam logic [2:0] ONES_STUFF = 3'h5;
  localparam logic [2:0] ONES_FLAG = 3'h6;
  localparam logic [2:0] DLY_LEN = 3'h7;
  localparam logic [2:0] OCTET_LAST = 3'h7;
  localparam logic [2:0] SEXTET_LAST = 3'h5;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    HLFC_EOM_GOOD = 2'b00,
    HLFC_EOM_ERROR = 2'b01,
    HLFC_EOM_ABORT = 2'b10,
    HLFC_EOM_PARTIAL = 2'b11
  } hlfc_eom_t;

  typedef enum logic [1:0] {
    HLFC_MODE_FCS = 2'b00,
    HLFC_MODE_NOFCS = 2'b01,
    HLFC_MODE_OCTET = 2'b10,
    HLFC_MODE_SEXTET = 2'b11
  } hlfc_mode_t;

  typedef enum logic [1:0] {
    HLFC_RX_HUNT = 2'b00,
    HLFC_RX_IDLE = 2'b01,
    HLFC_RX_MSG = 2'b10
  } hlfc_rx_t;

  // Fill limit in bytes; zero means disabled
  function automatic logic [5:0] fill_limit(input logic [1:0] sel,
                                            input logic t1Line);
    logic [5:0] step;
    step = t1Line ? T1_FILL_STEP : E1_FILL_STEP;
    unique case (sel)
      2'b00: fill_limit = 6'h00;
      2'b01: fill_limit = step;
      2'b10: fill_limit = step + step;
      2'b11: fill_limit = step + step + step;
    endcase
  endfunction

endpackage

// file: hlfc_ram_if.sv
// Write and read ports between the FIFO controller and its storage
`timescale 1ns/100ps
interface hlfc_ram_if;
  logic wrAEn;
  logic [5:0] wrAAddr;
  logic [7:0] wrAData;
  logic wrBEn;
  logic [5:0] wrBAddr;
  logic [7:0] wrBData;
  logic [5:0] rdAddr;
  logic [7:0] rdData;
  modport ctrl (output wrAEn, wrAAddr, wrAData, wrBEn, wrBAddr, wrBData,
                output rdAddr, input rdData);
  modport mem (input wrAEn, wrAAddr, wrAData, wrBEn, wrBAddr, wrBData,
               input rdAddr, output rdData);
endinterface

// file: hlfc_ram.sv
// 64 x 8 receive storage, two write ports, registered read
`timescale 1ns/100ps
module hlfc_ram (
  input wire logic clk,
  input wire logic rst,
  hlfc_ram_if.mem ram
);
  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [7:0] q;
  } hlfc_ram_state_t;

  hlfc_ram_state_t st_r;
  hlfc_ram_state_t st_nxt;

  // Port B rewrites a status slot, port A appends
  always_comb begin
    st_nxt = st_r;
    st_nxt.q = st_r.mem[ram.rdAddr];
    if (ram.wrBEn) begin
      st_nxt.mem[ram.wrBAddr] = ram.wrBData;
    end
    if (ram.wrAEn) begin
      st_nxt.mem[ram.wrAAddr] = ram.wrAData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ram.rdData = st_r.q;
endmodule // hlfc_ram

// file: hlfc_tx_level.sv
// Transmit near-empty level flag and interrupt pulse
`timescale 1ns/100ps
module hlfc_tx_level (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] threshold,
  input wire logic [6:0] fillCount,
  output logic nearEmptyFlag_r,
  output logic nearEmptyIrq_r
);
  typedef struct packed {
    logic flag;
    logic irq;
  } hlfc_tx_state_t;

  hlfc_tx_state_t st_r;
  hlfc_tx_state_t st_nxt;
  logic below;

  always_comb begin
    st_nxt = st_r;
    below = (threshold != 6'h00) && (fillCount < {1'b0, threshold}); // R21
    st_nxt.flag = below; // R21
    st_nxt.irq = below && !st_r.flag; // R21
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign nearEmptyFlag_r = st_r.flag;
  assign nearEmptyIrq_r = st_r.irq;
endmodule // hlfc_tx_level

// file: hlfc_link_fifo.sv
// Receive and transmit FIFO control of the second data link
`timescale 1ns/100ps

// What this block does
// R1 - Fill limit only in packing modes; on reaching it full irq, Partial.
// R2 - Fill limit 00 off; E1 gives 8/16/24 bytes, T1 gives 6/12/18.
// R3 - Near-full irq and flag when empty slots equal threshold; 0 is full.
// R4 - Near-full during a message raises message irq and writes Partial status.
// R5 - Status words and data bytes share the FIFO, one location each.
// R6 - Non-zero count status is followed by exactly that many data bytes.
// R7 - Status bits 7:6: 00 Good, 01 error, 10 Abort, 11 Partial.
// R8 - Status bits 5:0 hold the data byte count that follows, 0 to 63.
// R9 - Aborted or errored message reports count zero, its data discarded.
// R10 - Unformatted messages are reported with Partial code; here dropping rxEnable closes the open one with Abort code instead.
// R11 - Reading while a message fills returns Good with count zero.
// R12 - Seven or more consecutive ones inside a message report Abort.
// R13 - FCS mode reports error when received check sequence mismatches.
// R14 - Closing flag on a non-octet length reports non-integer error.
// R15 - Bytes fill LSB first; eight bits, or six in sextet mode.
// R16 - In-progress flag high between flags; high while rxEnable is set when unformatted.
// R17 - Next-is-status flag tells what the next read returns; zero if empty.
// R18 - Empty flag set when the FIFO holds nothing.
// R19 - At near-full the open status word becomes Partial; reads clear flag.
// R20 - Full FIFO is an error; open message becomes Partial with count zero.
// R21 - Transmit near-empty flag while fill is below threshold; irq pulses once as it drops below.
// R22 - Software reads the status register before each FIFO read.
// R23 - Each FIFO port read of a non-empty FIFO advances the read pointer; status reads do not.
module hlfc_link_fifo (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData_r,
  output logic regRdValid_r,
  input wire logic rxEnable,
  input wire logic [1:0] linkMode,
  input wire logic lineTypeSelect,
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic [6:0] txFillCount,
  output logic rxFullIrq_r,
  output logic rxNearFullIrq_r,
  output logic rxMessageIrq_r,
  output logic txNearEmptyIrq_r,
  output logic txNearEmptyFlag_r
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] fillCtrl;
    logic [7:0] emptyCtrl;
    logic [6:0] wrPtr;
    logic [6:0] rdPtr;
    logic [5:0] statPtr;
    logic [63:0] tags;
    logic slotOpen;
    logic slotRead;
    logic [5:0] msgCnt;
    hlfc_pkg::hlfc_rx_t rxSt;
    logic [2:0] ones;
    logic [6:0] dly;
    logic [2:0] dlyCnt;
    logic [7:0] asm;
    logic [2:0] bitCnt;
    logic [15:0] crc;
    logic [7:0] pend0;
    logic [7:0] pend1;
    logic [1:0] pendCnt;
    logic nearDone;
    logic nearPrev;
    logic rdPend;
    logic rdFifo;
    logic [7:0] rdAddr;
    logic [7:0] rdData;
    logic rdValid;
    logic fullIrq;
    logic nearIrq;
    logic msgIrq;
  } hlfc_state_t;

  hlfc_state_t st_r;
  hlfc_state_t st_nxt;
  hlfc_ram_if ramBus ();

  logic [6:0] count;
  logic isEmpty;
  logic isFull;
  logic nearHit;
  logic packMode;
  logic fcsMode;
  logic [5:0] limit;
  logic bitEv;
  logic inProg;
  logic nextStat;
  logic fifoRead;
  logic flagSeen;
  logic stuffSeen;
  logic abortSeen;
  logic byteDone;
  logic [7:0] byteVal;
  logic openReq;
  logic closeReq;
  logic closeKeep;
  hlfc_pkg::hlfc_eom_t closeCode;
  logic splitReq;
  logic aEn;
  logic [5:0] aAddr;
  logic [7:0] aData;
  logic aTag;
  logic bEn;
  logic [7:0] bData;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    count = st_r.wrPtr - st_r.rdPtr;
    isEmpty = (count == 7'h00); // R18
    isFull = (count == hlfc_pkg::FIFO_DEPTH);
    nearHit = count >= (hlfc_pkg::FIFO_DEPTH -
                        {1'b0, st_r.fillCtrl[hlfc_pkg::THRESH_MSB:0]}); // R3
    packMode = linkMode[1];
    fcsMode = (linkMode == hlfc_pkg::HLFC_MODE_FCS);
    limit = hlfc_pkg::fill_limit(
      st_r.fillCtrl[hlfc_pkg::FILL_LIMIT_LSB +: 2], lineTypeSelect); // R2
    bitEv = rxEnable && rxBitValid;
    inProg = packMode ? rxEnable : (st_r.rxSt == hlfc_pkg::HLFC_RX_MSG); // R16
    nextStat = !isEmpty && st_r.tags[st_r.rdPtr[5:0]]; // R17
    flagSeen = 1'b0;
    stuffSeen = 1'b0;
    abortSeen = 1'b0;
    byteDone = 1'b0;
    byteVal = 8'h00;
    openReq = 1'b0;
    closeReq = 1'b0;
    closeKeep = 1'b0;
    closeCode = hlfc_pkg::HLFC_EOM_GOOD;
    splitReq = 1'b0;
    aEn = 1'b0;
    aAddr = st_r.wrPtr[5:0];
    aData = 8'h00;
    aTag = 1'b0;
    bEn = 1'b0;
    bData = 8'h00;
    st_nxt.fullIrq = 1'b0;
    st_nxt.msgIrq = 1'b0;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    fifoRead = regRdEn && (regAddr == hlfc_pkg::FIFO_PORT_OFS) && !isEmpty;
    st_nxt.rdPend = regRdEn;
    st_nxt.rdAddr = regAddr;
    st_nxt.rdFifo = fifoRead;
    if (fifoRead) begin
      st_nxt.rdPtr = st_r.rdPtr + 7'h01; // R23
      if (st_r.slotOpen && (st_r.rdPtr[5:0] == st_r.statPtr)) begin
        st_nxt.slotRead = 1'b1;
      end
    end
    if (regWrEn && (regAddr == hlfc_pkg::FILL_CTRL_OFS)) begin
      st_nxt.fillCtrl = regWrData;
    end
    if (regWrEn && (regAddr == hlfc_pkg::EMPTY_CTRL_OFS)) begin
      st_nxt.emptyCtrl = {2'h0, regWrData[hlfc_pkg::THRESH_MSB:0]};
    end
    st_nxt.rdValid = st_r.rdPend;
    st_nxt.rdData = 8'h00;
    if (st_r.rdPend) begin
      unique case (st_r.rdAddr)
        hlfc_pkg::FILL_CTRL_OFS: st_nxt.rdData = st_r.fillCtrl;
        hlfc_pkg::FIFO_PORT_OFS: begin
          st_nxt.rdData = st_r.rdFifo ? ramBus.rdData : 8'h00;
        end
        hlfc_pkg::STATUS_OFS: begin
          st_nxt.rdData[hlfc_pkg::ST_IN_PROG] = inProg; // R16
          st_nxt.rdData[hlfc_pkg::ST_NEXT_STAT] = nextStat; // R17
          st_nxt.rdData[hlfc_pkg::ST_EMPTY] = isEmpty; // R18
          st_nxt.rdData[hlfc_pkg::ST_NEAR] = nearHit; // R3
          st_nxt.rdData[hlfc_pkg::ST_FULL] = isFull; // R20
        end
        hlfc_pkg::EMPTY_CTRL_OFS: st_nxt.rdData = st_r.emptyCtrl;
        default: st_nxt.rdData = 8'h00;
      endcase
    end

    // ------------------------------------------------------------------
    // Receive bit stream
    // ------------------------------------------------------------------
    if (!rxEnable) begin
      // Dropping enable mid-message aborts it; no dangling slot
      st_nxt.rxSt = hlfc_pkg::HLFC_RX_HUNT;
      st_nxt.ones = 3'h0;
      st_nxt.dlyCnt = 3'h0;
      st_nxt.bitCnt = 3'h0;
      st_nxt.pendCnt = 2'h0;
      st_nxt.crc = hlfc_pkg::CRC_INIT;
      closeReq = 1'b1;
      closeCode = hlfc_pkg::HLFC_EOM_ABORT;
    end else if (bitEv && packMode) begin
      if (linkMode == hlfc_pkg::HLFC_MODE_OCTET) begin
        st_nxt.asm = {rxBit, st_r.asm[7:1]}; // R15
        byteDone = (st_r.bitCnt == hlfc_pkg::OCTET_LAST);
      end else begin
        st_nxt.asm = {2'h0, rxBit, st_r.asm[5:1]}; // R15
        byteDone = (st_r.bitCnt == hlfc_pkg::SEXTET_LAST);
      end
      st_nxt.bitCnt = byteDone ? 3'h0 : st_r.bitCnt + 3'h1;
      byteVal = st_nxt.asm;
    end else if (bitEv) begin
      flagSeen = !rxBit && (st_r.ones == hlfc_pkg::ONES_FLAG);
      stuffSeen = !rxBit && (st_r.ones == hlfc_pkg::ONES_STUFF);
      abortSeen = rxBit && (st_r.ones == hlfc_pkg::ONES_FLAG);
      st_nxt.ones = !rxBit ? 3'h0 :
                    (st_r.ones == 3'h7) ? st_r.ones : st_r.ones + 3'h1;
      if (abortSeen) begin
        closeReq = 1'b1; // R12
        closeCode = hlfc_pkg::HLFC_EOM_ABORT; // R12
        st_nxt.rxSt = hlfc_pkg::HLFC_RX_HUNT;
      end else if (flagSeen) begin
        if (st_r.rxSt == hlfc_pkg::HLFC_RX_MSG) begin
          closeReq = 1'b1;
          if (st_r.bitCnt != 3'h0) begin
            closeCode = hlfc_pkg::HLFC_EOM_ERROR; // R14
          end else if (fcsMode && (st_r.crc != hlfc_pkg::CRC_GOOD)) begin
            closeCode = hlfc_pkg::HLFC_EOM_ERROR; // R13
          end else begin
            closeKeep = 1'b1;
          end
        end
        // Delay line holds the flag's head
        st_nxt.rxSt = hlfc_pkg::HLFC_RX_IDLE;
        st_nxt.dlyCnt = 3'h0;
        st_nxt.bitCnt = 3'h0;
        st_nxt.crc = hlfc_pkg::CRC_INIT;
        st_nxt.pendCnt = 2'h0;
      end else if (!stuffSeen && (st_r.rxSt != hlfc_pkg::HLFC_RX_HUNT)) begin
        st_nxt.dly = {rxBit, st_r.dly[6:1]};
        if (st_r.dlyCnt != hlfc_pkg::DLY_LEN) begin
          st_nxt.dlyCnt = st_r.dlyCnt + 3'h1;
        end else begin
          if (st_r.rxSt == hlfc_pkg::HLFC_RX_IDLE) begin
            st_nxt.rxSt = hlfc_pkg::HLFC_RX_MSG;
            openReq = 1'b1;
          end
          st_nxt.crc = (st_r.crc >> 1) ^
            ((st_r.crc[0] ^ st_r.dly[0]) ? hlfc_pkg::CRC_POLY : 16'h0000); // R13
          st_nxt.asm = {st_r.dly[0], st_r.asm[7:1]}; // R15
          st_nxt.bitCnt = st_r.bitCnt + 3'h1;
          if (st_r.bitCnt == hlfc_pkg::OCTET_LAST) begin
            if (!fcsMode) begin
              byteDone = 1'b1;
              byteVal = st_nxt.asm;
            end else begin
              // Hold two bytes back so the FCS never lands
              if (st_r.pendCnt == 2'h2) begin
                byteDone = 1'b1;
                byteVal = st_r.pend0;
                st_nxt.pend0 = st_r.pend1;
                st_nxt.pend1 = st_nxt.asm;
              end else if (st_r.pendCnt == 2'h1) begin
                st_nxt.pend1 = st_nxt.asm;
                st_nxt.pendCnt = 2'h2;
              end else begin
                st_nxt.pend0 = st_nxt.asm;
                st_nxt.pendCnt = 2'h1;
              end
            end
          end
        end
      end
    end

    // ------------------------------------------------------------------
    // Message bookkeeping
    // ------------------------------------------------------------------
    if (packMode && rxEnable && !st_r.slotOpen && !isFull && !bitEv) begin
      openReq = 1'b1;
    end
    if (byteDone && st_r.slotOpen && isFull) begin
      byteDone = 1'b0;
      closeReq = 1'b1; // R20
      closeCode = hlfc_pkg::HLFC_EOM_PARTIAL; // R20
      st_nxt.fullIrq = 1'b1;
    end
    if (st_r.slotOpen && (st_r.msgCnt != 6'h00) && !bitEv && rxEnable) begin
      if (packMode && (limit != 6'h00) && (st_r.msgCnt == limit)) begin
        splitReq = 1'b1; // R1
        st_nxt.fullIrq = 1'b1; // R1
      end else if (nearHit && !st_r.nearDone) begin
        splitReq = 1'b1; // R4
        st_nxt.msgIrq = 1'b1; // R4
        st_nxt.nearDone = 1'b1;
      end
    end
    if (!nearHit) begin
      st_nxt.nearDone = 1'b0;
    end
    st_nxt.nearPrev = nearHit;
    st_nxt.nearIrq = nearHit && !st_r.nearPrev; // R3

    if (closeReq && st_r.slotOpen) begin
      st_nxt.slotOpen = 1'b0;
      st_nxt.msgCnt = 6'h00;
      st_nxt.msgIrq = 1'b1;
      if (closeKeep) begin
        bEn = 1'b1;
        bData = {closeCode, st_r.msgCnt}; // R7
      end else if (!st_r.slotRead) begin
        bEn = 1'b1;
        bData = {closeCode, 6'h00}; // R9
        st_nxt.wrPtr = st_r.wrPtr - {1'b0, st_r.msgCnt}; // R9
      end else begin
        // Slot already read: drop unread bytes, append a word
        aEn = 1'b1;
        aAddr = st_nxt.rdPtr[5:0];
        aData = {closeCode, 6'h00}; // R9
        aTag = 1'b1;
        st_nxt.wrPtr = st_nxt.rdPtr + 7'h01;
      end
    end else if (splitReq) begin
      bEn = 1'b1;
      bData = {hlfc_pkg::HLFC_EOM_PARTIAL, st_r.msgCnt}; // R10 R19
      st_nxt.msgCnt = 6'h00;
      if (isFull) begin
        st_nxt.slotOpen = 1'b0;
      end else begin
        openReq = 1'b1;
      end
    end
    if (openReq && !isFull && !(closeReq && st_r.slotOpen)) begin
      aEn = 1'b1;
      aData = {hlfc_pkg::HLFC_EOM_GOOD, 6'h00}; // R11
      aTag = 1'b1; // R5
      st_nxt.statPtr = st_r.wrPtr[5:0];
      st_nxt.wrPtr = st_r.wrPtr + 7'h01;
      st_nxt.slotOpen = 1'b1;
      st_nxt.slotRead = 1'b0;
      st_nxt.msgCnt = 6'h00;
    end else if (byteDone && st_r.slotOpen && !closeReq) begin
      aEn = 1'b1;
      aData = byteVal; // R5
      st_nxt.wrPtr = st_r.wrPtr + 7'h01;
      st_nxt.msgCnt = st_r.msgCnt + 6'h01; // R6 R8
    end
    if (aEn) begin
      st_nxt.tags[aAddr] = aTag; // R17
    end
  end

  // --------------------------------------------------------------------
  // Registers and submodules
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.fillCtrl <= hlfc_pkg::FILL_CTRL_RST;
      st_r.emptyCtrl <= hlfc_pkg::EMPTY_CTRL_RST;
      st_r.rxSt <= hlfc_pkg::HLFC_RX_HUNT;
      st_r.crc <= hlfc_pkg::CRC_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ramBus.wrAEn = aEn;
  assign ramBus.wrAAddr = aAddr;
  assign ramBus.wrAData = aData;
  assign ramBus.wrBEn = bEn;
  assign ramBus.wrBAddr = st_r.statPtr;
  assign ramBus.wrBData = bData;
  assign ramBus.rdAddr = st_r.rdPtr[5:0];

  hlfc_ram u_ram (
    .clk(clk),
    .rst(rst),
    .ram(ramBus.mem)
  );

  hlfc_tx_level u_tx_level (
    .clk(clk),
    .rst(rst),
    .threshold(st_r.emptyCtrl[hlfc_pkg::THRESH_MSB:0]),
    .fillCount(txFillCount),
    .nearEmptyFlag_r(txNearEmptyFlag_r),
    .nearEmptyIrq_r(txNearEmptyIrq_r)
  );

  assign regRdData_r = st_r.rdData;
  assign regRdValid_r = st_r.rdValid;
  assign rxFullIrq_r = st_r.fullIrq;
  assign rxNearFullIrq_r = st_r.nearIrq;
  assign rxMessageIrq_r = st_r.msgIrq;
endmodule // hlfc_link_fifo

// file: hlfc_link_fifo_asserts.sv
// Concurrent checks on the link FIFO ports
`timescale 1ns/100ps
module hlfc_link_fifo_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData_r,
  input wire logic regRdValid_r,
  input wire logic [6:0] txFillCount,
  input wire logic rxFullIrq_r,
  input wire logic rxMessageIrq_r,
  input wire logic txNearEmptyIrq_r,
  input wire logic txNearEmptyFlag_r
);
  // ------
  // Register mirrors
  // ------
  logic [7:0] fill_r;
  logic [5:0] thr_r;
  logic [5:0] thrOld_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_r <= 8'h00;
      thr_r <= 6'h00;
      thrOld_r <= 6'h00;
    end else begin
      if (regWrEn && regAddr == hlfc_pkg::FILL_CTRL_OFS) begin
        fill_r <= regWrData;
      end
      if (regWrEn && regAddr == hlfc_pkg::EMPTY_CTRL_OFS) begin
        thr_r <= regWrData[5:0];
      end
      thrOld_r <= thr_r;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ------
  // Properties
  // ------
  sequence rdOf(a);
    regRdEn && !regWrEn && regAddr == a;
  endsequence
  sequence answer(d);
    ##2 regRdValid_r && regRdData_r == d;
  endsequence
  a_read_latency: assert property (regRdEn |-> ##2 regRdValid_r)
    else $error("read answer missing");
  a_data_quiet: assert property (!regRdValid_r |-> regRdData_r == 8'h00)
    else $error("idle data not zero");
  a_fill_readback: assert property (
    rdOf(hlfc_pkg::FILL_CTRL_OFS) |-> answer($past(fill_r, 2)))
    else $error("fill readback");
  a_thresh_readback: assert property (
    rdOf(hlfc_pkg::EMPTY_CTRL_OFS) |-> answer({2'b00, $past(thr_r, 2)}))
    else $error("empty readback");
  a_tx_flag_level: assert property (
    txNearEmptyFlag_r == (thrOld_r != 6'h00 &&
    $past(txFillCount) < {1'b0, thrOld_r}))
    else $error("near empty flag wrong");
  a_tx_irq_rise: assert property (
    $rose(txNearEmptyFlag_r) |-> ##[0:1] txNearEmptyIrq_r)
    else $error("near empty irq missing");
  a_msg_irq_pulse: assert property (rxMessageIrq_r |=> !rxMessageIrq_r)
    else $error("msg irq too long");
  a_full_irq_pulse: assert property (rxFullIrq_r |=> !rxFullIrq_r)
    else $error("full irq too long");
endmodule // hlfc_link_fifo_asserts

bind hlfc_link_fifo hlfc_link_fifo_asserts u_asserts (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData_r(regRdData_r),
  .regRdValid_r(regRdValid_r), .txFillCount(txFillCount),
  .rxFullIrq_r(rxFullIrq_r), .rxMessageIrq_r(rxMessageIrq_r),
  .txNearEmptyIrq_r(txNearEmptyIrq_r),
  .txNearEmptyFlag_r(txNearEmptyFlag_r));

// file: hlfc_host_model.sv
// Host model on the register port
`timescale 1ns/100ps
module hlfc_host_model (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic regRdValid_r
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    @(negedge clk);
  endtask
endmodule // hlfc_host_model

// file: hlfc_link_fifo_tb.sv
// Testbench for the link FIFO control block
`timescale 1ns/100ps
module hlfc_link_fifo_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData_r, v;
  logic regWrEn, regRdEn, regRdValid_r, rxEnable, lineTypeSelect;
  logic rxBitValid, rxBit, rxFullIrq_r, rxNearFullIrq_r, rxMessageIrq_r;
  logic txNearEmptyIrq_r, txNearEmptyFlag_r;
  logic [1:0] linkMode;
  logic [6:0] txFillCount;
  logic [5:0] thr;
  logic [7:0] d[24];
  logic [15:0] e;
  logic [15:0] expQ[$];
  int failures = 0, comparisons = 0, seed = 61690, cycles = 0;
  int fullIrqs = 0, nearIrqs = 0, ones = 0, lim, n0;
  always #2 clk = ~clk;
  hlfc_host_model host (.clk(clk), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdValid_r(regRdValid_r));
  hlfc_link_fifo DUT (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r),
    .rxEnable(rxEnable), .linkMode(linkMode),
    .lineTypeSelect(lineTypeSelect), .rxBitValid(rxBitValid),
    .rxBit(rxBit), .txFillCount(txFillCount), .rxFullIrq_r(rxFullIrq_r),
    .rxNearFullIrq_r(rxNearFullIrq_r), .rxMessageIrq_r(rxMessageIrq_r),
    .txNearEmptyIrq_r(txNearEmptyIrq_r),
    .txNearEmptyFlag_r(txNearEmptyFlag_r));
  // ------
  // Checking and drivers
  // ------
  task automatic check(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    failures += expQ.size();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic rdChk(input logic [7:0] a, m, x);
    expQ.push_back({m, x});
    host.rd(a);
  endtask
  task automatic fifoChk(input logic [7:0] s, x);
    expQ.push_back({8'h1D, s});
    expQ.push_back({8'hFF, x});
    host.rd(hlfc_pkg::STATUS_OFS);
    host.rd(hlfc_pkg::FIFO_PORT_OFS);
  endtask
  task automatic sendBits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rxBit = b[i];
      rxBitValid = 1'b1;
      @(negedge clk);
      rxBitValid = 1'b0;
      rxBit = ~b[i];
    end
  endtask
  task automatic sendData(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      sendBits({7'h00, b[i]}, 1);
      ones = b[i] ? ones + 1 : 0;
      if (ones == 5) begin
        sendBits(8'h00, 1);
        ones = 0;
      end
    end
  endtask
  task automatic flag();
    sendBits(8'h7E, 8);
    ones = 0;
  endtask
  always @(negedge clk) begin
    cycles++;
    fullIrqs += (rxFullIrq_r === 1'b1);
    nearIrqs += (rxNearFullIrq_r === 1'b1);
    if (regRdValid_r === 1'b1) begin
      e = expQ.size() ? expQ.pop_front() : 16'h00FF;
      check(regRdData_r & e[15:8], e[7:0]);
    end
    if (cycles == 10000) begin
      failures++;
      final_report();
    end
  end
  // ------
  // Scenarios
  // ------
  initial begin
    rxEnable = 1'b0;
    linkMode = hlfc_pkg::HLFC_MODE_OCTET;
    lineTypeSelect = 1'b0;
    rxBitValid = 1'b0;
    rxBit = 1'b0;
    txFillCount = 7'h00;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rdChk(hlfc_pkg::FILL_CTRL_OFS, 8'hFF, hlfc_pkg::FILL_CTRL_RST);
    rdChk(hlfc_pkg::STATUS_OFS, 8'h1F, 8'h04);
    rdChk(hlfc_pkg::FIFO_PORT_OFS, 8'hFF, 8'h00);
    rdChk(8'hB5, 8'hFF, 8'h00);
    v = $random(seed);
    host.wr(hlfc_pkg::FIFO_PORT_OFS, v);
    rdChk(hlfc_pkg::STATUS_OFS, 8'h1F, 8'h04);
    for (int t = 0; t < 5; t++) begin
      thr = t ? 6'($random(seed)) : 6'h00;
      host.wr(hlfc_pkg::EMPTY_CTRL_OFS, {2'b11, thr});
      rdChk(hlfc_pkg::EMPTY_CTRL_OFS, 8'hFF, {2'b00, thr});
      for (int f = 0; f < 6; f++) begin
        txFillCount = (f < 3 && thr != 0) ? 7'(thr + f - 1)
                                          : 7'({$random(seed)} % 65);
        repeat (2) @(negedge clk);
        check({7'h00, txNearEmptyFlag_r},
              {7'h00, thr != 0 && txFillCount < thr});
      end
    end
    for (int c = 0; c < 3; c++) begin
      lineTypeSelect = c[0];
      linkMode = {1'b1, c[0]};
      lim = c[0] ? 6 * (c + 1) : 8 * (c + 1);
      host.wr(hlfc_pkg::FILL_CTRL_OFS, {2'(c + 1), 6'h00});
      rxEnable = 1'b1;
      repeat (4) @(negedge clk);
      n0 = fullIrqs;
      for (int i = 0; i < lim; i++) begin
        d[i] = $random(seed);
        sendBits(d[i], c[0] ? 6 : 8);
      end
      repeat (20) @(negedge clk);
      check(8'(fullIrqs - n0), 8'h01);
      fifoChk(8'h18, {2'b11, 6'(lim)});
      for (int i = 0; i < lim; i++) begin
        fifoChk(8'h10, d[i] & (c[0] ? 8'h3F : 8'hFF));
      end
      fifoChk(8'h18, 8'h00);
      rxEnable = 1'b0;
      repeat (6) @(negedge clk);
      fifoChk(8'h08, 8'h80);
      rdChk(hlfc_pkg::STATUS_OFS, 8'h1F, 8'h04);
    end
    linkMode = hlfc_pkg::HLFC_MODE_NOFCS;
    host.wr(hlfc_pkg::FILL_CTRL_OFS, 8'h00);
    rxEnable = 1'b1;
    d[0] = 8'hFF;
    d[1] = $random(seed);
    flag();
    sendData(d[0]);
    sendData(d[1]);
    flag();
    flag();
    fifoChk(8'h08, 8'h02);
    fifoChk(8'h00, d[0]);
    fifoChk(8'h00, d[1]);
    flag();
    sendData(d[1]);
    sendBits(8'hFF, 8);
    flag();
    flag();
    fifoChk(8'h08, 8'h80);
    rxEnable = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    linkMode = hlfc_pkg::HLFC_MODE_OCTET;
    host.wr(hlfc_pkg::FILL_CTRL_OFS, 8'h3C);
    rxEnable = 1'b1;
    n0 = nearIrqs;
    lim = fullIrqs;
    for (int i = 0; i < 70; i++) begin
      v = $random(seed);
      if (i < 3) d[i] = v;
      sendBits(v, 8);
    end
    repeat (20) @(negedge clk);
    check(8'(nearIrqs - n0), 8'h01);
    check(8'(fullIrqs > lim), 8'h01);
    fifoChk(8'h18, 8'hC3);
    for (int i = 0; i < 3; i++) begin
      fifoChk(8'h10, d[i]);
    end
    fifoChk(8'h18, 8'hC0);
    rxEnable = 1'b0;
    repeat (4) @(negedge clk);
    rdChk(hlfc_pkg::STATUS_OFS, 8'h02, 8'h00);
    repeat (2) @(negedge clk);
    final_report();
  end
endmodule // hlfc_link_fifo_tb
